/* File: fetch_addr_pkg.sv */
/*
 Constants and carrier types for the instruction address generator.
 Assumes a single 40 MHz core clock and a 16-bit program address space.
*/
// How it works
// RULE_01 - No branch: pointer advances by the byte count just fetched.
// RULE_02 - A taken branch loads its destination instead of the increment.
// RULE_03 - Relative target is next-instruction start plus the 8-bit offset.
// RULE_04 - Offset is two's complement, bit 7 sign, reach -128..+127.
// RULE_05 - Short jump and met conditional branches take the relative target.
// RULE_06 - Absolute call and jump copy the 16-bit immediate into the pointer.
// RULE_07 - Table call loads the entry at 40H..7FH picked by code bits 1-5.
// RULE_08 - Register jump loads the pointer from the accumulator pair.
// RULE_09 - After reset the pointer is loaded from bytes at 0000H and 0001H.
// RULE_10 - All pointer additions wrap modulo 2^16, carry discarded.
package fetch_addr_pkg;

   // ----------------------------------------
   // Address and field constants
   // ----------------------------------------
   localparam logic [15:0] VECTOR_LO_ADDR = 16'h0000;
   localparam logic [15:0] VECTOR_HI_ADDR = 16'h0001;
   localparam logic [15:0] TABLE_BASE     = 16'h0040;
   localparam int          SIGN_BIT       = 7;
   localparam int          IDX_LSB        = 1;
   localparam int          IDX_MSB        = 5;
   localparam logic [15:0] ZERO_ADDR      = 16'h0000;
   localparam logic [2:0]  LEN_ZERO       = 3'h0;

   // ----------------------------------------
   // Branch kinds
   // ----------------------------------------
   typedef enum logic [2:0] {
      JUMP_NONE,
      JUMP_REL,
      JUMP_REL_COND,
      JUMP_ABS,
      JUMP_TABLE,
      JUMP_REG
   } jump_op_t;

   // ----------------------------------------
   // Step request from the sequencer
   // ----------------------------------------
   typedef struct packed {
      logic       valid;
      logic [2:0] length;
      jump_op_t   op;
      logic       cond_met;
      logic [7:0] signed_hop_offset;
      logic [15:0] absolute_target_field;
      logic [7:0] opcode;
      logic [15:0] accumulator_pair;
   } step_req_t;

   // ----------------------------------------
   // Memory read port
   // ----------------------------------------
   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } mem_req_t;

endpackage : fetch_addr_pkg

/* File: fetch_pointer_gen.sv */
/*
 Fetch pointer generation: sequential advance, branch targets and
 reset vector load. Assumes memory answers a read in the same cycle as
 mem_req.rd with the byte on mem_rdata.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_pointer_gen
   import fetch_addr_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Sequencer step
   input  wire step_req_t   step,
   // Program memory
   output var mem_req_t     mem_req,
   input  wire logic [7:0]  mem_rdata,
   // Status
   output logic [15:0]      fetch_pointer,
   output logic             ready,
   output logic             step_done
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {
      S_VEC_LO, S_VEC_LO_WAIT, S_VEC_HI_WAIT,
      S_RUN, S_TAB_LO_WAIT, S_TAB_HI_WAIT
   } state_t;

   state_t      state_reg, state_next;
   logic [15:0] fp_reg, fp_next;
   logic [7:0]  lo_reg, lo_next;
   mem_req_t    mreq_reg, mreq_next;
   logic        ready_reg, ready_next;
   logic        done_reg, done_next;

   // ----------------------------------------
   // Target arithmetic
   // ----------------------------------------
   logic [15:0] seq_addr;
   logic [15:0] hop_ext;
   logic [15:0] rel_addr;
   logic [15:0] len_ext;
   logic [15:0] tab_addr;
   logic [15:0] tab_off;
   logic        rel_take;
   logic        abs_take;
   logic        reg_take;
   logic        tab_take;
   logic        go;

   assign len_ext = {13'h0000, step.length};
   assign hop_ext = {{8{step.signed_hop_offset[SIGN_BIT]}},
                     step.signed_hop_offset};  // see RULE_04
   assign tab_off = {10'h000, step.opcode[IDX_MSB:IDX_LSB], 1'b0};

   fetch_sum u_seq (  // see RULE_01
      .base  (fp_reg),
      .delta (len_ext),
      .sum   (seq_addr)
   );
   fetch_sum u_rel (  // see RULE_03
      .base  (seq_addr),
      .delta (hop_ext),
      .sum   (rel_addr)
   );
   fetch_sum u_tab (  // see RULE_07
      .base  (TABLE_BASE),
      .delta (tab_off),
      .sum   (tab_addr)
   );

   assign go       = ready_reg & step.valid;
   assign rel_take = (step.op == JUMP_REL) |  // see RULE_05
                     ((step.op == JUMP_REL_COND) & step.cond_met);
   assign abs_take = step.op == JUMP_ABS;
   assign reg_take = step.op == JUMP_REG;
   assign tab_take = step.op == JUMP_TABLE;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      fp_next    = fp_reg;
      lo_next    = lo_reg;
      mreq_next  = '{rd: 1'b0, addr: ZERO_ADDR};
      ready_next = ready_reg;
      done_next  = 1'b0;
      unique case (state_reg)
         S_VEC_LO: begin
            mreq_next  = '{rd: 1'b1, addr: VECTOR_LO_ADDR};  // see RULE_09
            state_next = S_VEC_LO_WAIT;
         end
         S_VEC_LO_WAIT: begin
            lo_next    = mem_rdata;
            mreq_next  = '{rd: 1'b1, addr: VECTOR_HI_ADDR};  // see RULE_09
            state_next = S_VEC_HI_WAIT;
         end
         S_VEC_HI_WAIT: begin
            fp_next    = {mem_rdata, lo_reg};  // see RULE_09
            ready_next = 1'b1;
            state_next = S_RUN;
         end
         S_RUN: begin
            if (go) begin
               done_next = 1'b1;
               if (rel_take) begin
                  fp_next = rel_addr;  // see RULE_02
               end else if (abs_take) begin
                  fp_next = step.absolute_target_field;  // see RULE_06
               end else if (reg_take) begin
                  fp_next = step.accumulator_pair;  // see RULE_08
               end else if (tab_take) begin
                  done_next  = 1'b0;
                  ready_next = 1'b0;
                  mreq_next  = '{rd: 1'b1, addr: tab_addr};
                  state_next = S_TAB_LO_WAIT;
               end else begin
                  fp_next = seq_addr;  // see RULE_01
               end
            end
         end
         S_TAB_LO_WAIT: begin
            lo_next    = mem_rdata;
            mreq_next  = '{rd: 1'b1, addr: mreq_reg.addr + 16'h0001};
            state_next = S_TAB_HI_WAIT;
         end
         S_TAB_HI_WAIT: begin
            fp_next    = {mem_rdata, lo_reg};  // see RULE_07
            ready_next = 1'b1;
            done_next  = 1'b1;
            state_next = S_RUN;
         end
         default: begin
            state_next = S_VEC_LO;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= S_VEC_LO;
         fp_reg    <= ZERO_ADDR;
         lo_reg    <= 8'h00;
         mreq_reg  <= '{rd: 1'b0, addr: ZERO_ADDR};
         ready_reg <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         fp_reg    <= fp_next;
         lo_reg    <= lo_next;
         mreq_reg  <= mreq_next;
         ready_reg <= ready_next;
         done_reg  <= done_next;
      end
   end

   assign fetch_pointer = fp_reg;
   assign mem_req       = mreq_reg;
   assign ready         = ready_reg;
   assign step_done     = done_reg;

endmodule : fetch_pointer_gen
`default_nettype wire

/* File: fetch_pointer_gen_checker.sv */
/* Port checker for the fetch pointer generator.
 Assumes program memory answers in the cycle of the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module fetch_pointer_gen_checker
   import fetch_addr_pkg::*;
(
   // Watched ports
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire step_req_t   step,
   input wire mem_req_t    mem_req,
   input wire logic [7:0]  mem_rdata,
   input wire logic [15:0] fetch_pointer,
   input wire logic        ready,
   input wire logic        step_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic        go  = ready && step.valid;
   wire logic [15:0] nxt = fetch_pointer + 16'(step.length);
   wire logic [15:0] hop = {{8{step.signed_hop_offset[7]}},
                            step.signed_hop_offset};
   wire logic [15:0] tab = TABLE_BASE + {10'h0, step.opcode[5:1], 1'b0};
   chk_seq_advance: assert property (
      go && step.op == JUMP_NONE |=> step_done && fetch_pointer == $past(nxt))
      else $error("sequential advance wrong");
   chk_rel_target: assert property (
      go && (step.op == JUMP_REL ||
             (step.op == JUMP_REL_COND && step.cond_met))
      |=> fetch_pointer == $past(nxt + hop))
      else $error("relative target wrong");
   chk_cond_skip: assert property (
      go && step.op == JUMP_REL_COND && !step.cond_met
      |=> fetch_pointer == $past(nxt)) else $error("unmet branch not skipped");
   chk_abs_load: assert property (
      go && step.op == JUMP_ABS |=> fetch_pointer ==
      $past(step.absolute_target_field)) else $error("absolute load wrong");
   chk_reg_load: assert property (
      go && step.op == JUMP_REG |=> fetch_pointer ==
      $past(step.accumulator_pair)) else $error("register load wrong");
   chk_table_addr: assert property (
      go && step.op == JUMP_TABLE |=> mem_req.rd && mem_req.addr == $past(tab)
      ##1 mem_req.rd && mem_req.addr == $past(tab, 2) + 16'h1)
      else $error("table entry address wrong");
   chk_table_done: assert property (
      go && step.op == JUMP_TABLE |=> !ready && !step_done
      ##1 !ready && !step_done ##1 ready && step_done)
      else $error("table step timing wrong");
   chk_pair_load: assert property (
      $rose(ready) |-> fetch_pointer ==
      {$past(mem_rdata), $past(mem_rdata, 2)})
      else $error("loaded byte pair wrong");
   chk_vector_addr: assert property (
      $fell(rst) |=> mem_req.rd && mem_req.addr == VECTOR_LO_ADDR
      ##1 mem_req.rd && mem_req.addr == VECTOR_HI_ADDR)
      else $error("vector fetch address wrong");
endmodule : fetch_pointer_gen_checker
`default_nettype wire

/* File: fetch_sum.sv */
/*
 Wrapping 16-bit adder used for pointer arithmetic.
 Assumes purely combinational use by the pointer logic.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_sum
   import fetch_addr_pkg::*;
(
   // Operands
   input  wire logic [15:0] base,
   input  wire logic [15:0] delta,
   // Result
   output logic      [15:0] sum
);
   logic [16:0] full;
   assign full = {1'b0, base} + {1'b0, delta};
   assign sum  = full[15:0];  // see RULE_10
endmodule : fetch_sum
`default_nettype wire

/* File: program_memory_model.sv */
/* Program memory: byte = low address byte xor a5.
 Assumes registered read strobe; idle data shows inverted last byte. */
`timescale 1ns/1ps
`default_nettype none
module program_memory_model
   import fetch_addr_pkg::*;
(
   // Port
   input wire logic       sys_clk,
   input wire mem_req_t   mem_req,
   output logic     [7:0] mem_rdata
);
   logic [7:0] last_reg = 8'h00;
   always_comb mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ 8'ha5) : ~last_reg;
   always_ff @(posedge sys_clk) begin
      if (mem_req.rd) last_reg <= mem_rdata;
   end
endmodule : program_memory_model
`default_nettype wire

/* File: test_instruction_address_generation.sv */
/* Testbench for the fetch pointer generator.
 Assumes the memory model contents of addr xor a5. */
`timescale 1ns/1ps
`default_nettype none
module test_instruction_address_generation
   import fetch_addr_pkg::*;
;
   logic        sys_clk    = 1'b0;
   logic        rst        = 1'b1;
   step_req_t   step       = '0;
   mem_req_t    mem_req;
   logic [7:0]  mem_rdata;
   logic [15:0] fetch_pointer;
   logic        ready;
   logic        step_done;
   logic [15:0] fp;
   int          fail_count = 0;
   int          compares   = 0;
   always #12.5 sys_clk = ~sys_clk;
   fetch_pointer_gen u_dut (.sys_clk(sys_clk), .rst(rst), .step(step),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .fetch_pointer(fetch_pointer),
      .ready(ready), .step_done(step_done));
   program_memory_model u_mem (.sys_clk(sys_clk), .mem_req(mem_req),
      .mem_rdata(mem_rdata));
   task automatic finish_test;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : check
   task automatic wait_hi(input bit done);
      int n;
      n = 0;
      while ((done ? step_done : ready) !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 8) begin
            check(1'b0, "wait timed out");
            finish_test();
         end
      end
   endtask : wait_hi
   task automatic do_step(input step_req_t s, input string msg);
      @(posedge sys_clk);
      #1;
      wait_hi(0);
      step = s;
      step.valid = 1'b1;
      @(posedge sys_clk);
      #1;
      step.valid = 1'b0;
      wait_hi(1);
      check(fetch_pointer === fp, msg);
   endtask : do_step
   task automatic t_reset;
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      wait_hi(0);
      fp = 16'ha4a5;
      check(fetch_pointer === fp, "vector");
   endtask : t_reset
   task automatic t_seq;
      step_req_t s;
      s = '0;
      for (int i = 1; i < 5; i++) begin
         s.length = 3'(i);
         fp = fp + 16'(i);
         do_step(s, "sequential");
      end
   endtask : t_seq
   task automatic t_rel;
      step_req_t s;
      s = '0;
      s.length = 3'h2;
      for (int i = 0; i < 4; i++) begin
         s.op = i[0] ? JUMP_REL_COND : JUMP_REL;
         s.cond_met = i[1];
         s.signed_hop_offset = i[1] ? 8'h80 : 8'h7f;
         fp = fp + 16'h2;
         if (!i[0] || i[1]) begin
            fp = fp + {{8{s.signed_hop_offset[7]}}, s.signed_hop_offset};
         end
         do_step(s, "relative");
      end
   endtask : t_rel
   task automatic t_jump;
      step_req_t s;
      s = '0;
      s.op = JUMP_ABS;
      s.absolute_target_field = 16'hfffe;
      fp = 16'hfffe;
      do_step(s, "absolute");
      s.op = JUMP_NONE;
      s.length = 3'h3;
      fp = 16'h0001;
      do_step(s, "wrap");
      s.op = JUMP_REG;
      s.accumulator_pair = 16'h8001;
      fp = 16'h8001;
      do_step(s, "register");
      s.op = JUMP_TABLE;
      s.opcode = 8'h3e;
      fp = 16'hdadb;
      do_step(s, "table top");
      s.opcode = 8'h00;
      fp = 16'he4e5;
      do_step(s, "table base");
   endtask : t_jump
   initial begin
      t_reset();
      t_seq();
      t_rel();
      t_jump();
      t_reset();
      t_seq();
      finish_test();
   end
endmodule : test_instruction_address_generation
bind fetch_pointer_gen fetch_pointer_gen_checker u_chk (.sys_clk(sys_clk),
   .rst(rst), .step(step), .mem_req(mem_req), .mem_rdata(mem_rdata),
   .fetch_pointer(fetch_pointer), .ready(ready), .step_done(step_done));
`default_nettype wire
